/* File: include/psut_pkg.sv */
// Purpose: Shared constants and types for the supply telemetry block
// Assumes: 100 MHz system clock, analog readings arrive already digitised
// Notes: Output voltages in 10 mV units, input voltage in volts, currents in 100 mA units, temperatures in degC
//
// Function
// RULE1: Track highest incoming-air temperature since power-up, clamped -45..150 degC.
// RULE2: Report primary-side temperature clamped to -45..150 degC.
// RULE3: Track primary-side temperature peak since power-up, clamped -45..150 degC.
// RULE4: Keep non-volatile operating hours, capped at 262800.
// RULE5: Keep non-volatile operating minutes, never above 59.
// RULE6: Count input transients overall and over the last two minutes, capped 7200000.
// RULE7: Report RMS input voltage capped at 1130 V.
// RULE8: Report output voltage capped at 40 V; above setpoint flags back-feeding.
// RULE9: Increment non-volatile turn-on counter each power-up, capped at 7200000.
// RULE10: Report hours since boot, restarted at boot, capped at 1000000.
// RULE11: Report minutes since boot, never above 59.
// RULE12: Health bit is one while the non-volatile memory works.
// RULE13: Shut-down bit one disables output, zero re-enables it.
// RULE14: Output-good event once output reaches 90 percent of setpoint.
// RULE15: Dip warning when output falls more than 10 percent below setpoint.
// RULE16: Dip warning lasts at least 250 ms.
// RULE17: Dips shorter than 1 ms raise no warning.
// RULE18: Overpower event while reserve power runs and current exceeds 105 percent.
// RULE19: Refresh parameter values every 50 ms.
// RULE20: Publish two-byte output current every 2 ms.
// RULE21: Shut down at once; restart within 350 ms of clearing the bit.
// RULE22: Minutes wrap 59 to zero and carry into hours.
// RULE23: Every counter saturates at its maximum.
package psut_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 100000000;
	localparam int MS_CYC = CLK_HZ / 1000;
	localparam int REFRESH_MS = 50;
	localparam int PD_MS = 2;
	localparam int DIP_MIN_MS = 1;
	localparam int DIP_MIN_CYC = DIP_MIN_MS * MS_CYC;
	localparam int STRETCH_MS = 250;
	localparam int RESTART_MS = 350;
	localparam int MINUTE_S = 60;
	localparam int MINUTE_MS = MINUTE_S * 1000;
	localparam int WIN_MIN = 2;
	localparam int WIN_MS = WIN_MIN * MINUTE_MS;

	// ****************************************************************
	// Widths and limits
	// ****************************************************************
	typedef logic signed [8:0] psut_temp_t;
	localparam psut_temp_t TEMP_MIN = -9'sh02D;
	localparam psut_temp_t TEMP_MAX = 9'sh096;
	localparam logic [22:0] OPH_MAX = 23'h040290;
	localparam logic [22:0] UPH_MAX = 23'h0F4240;
	localparam logic [22:0] CNT_MAX = 23'h6DDD00;
	localparam logic [5:0] MIN_MAX = 6'h3B;
	localparam logic [10:0] VIN_MAX = 11'h46A;
	localparam logic [11:0] VOUT_MAX = 12'hFA0;
	localparam logic [15:0] INOM = 16'h0190;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [6:0] GOOD_PCT = 7'h5A;
	localparam logic [6:0] OVP_PCT = 7'h69;

	// ****************************************************************
	// State encodings
	// ****************************************************************
	typedef enum logic [1:0] {
		PSUT_INIT = 2'b01,
		PSUT_RUN = 2'b10
	} psut_main_e;

	typedef enum logic [2:0] {
		PSUT_DIP_IDLE = 3'b001,
		PSUT_DIP_QUAL = 3'b010,
		PSUT_DIP_HOLD = 3'b100
	} psut_dip_e;

endpackage

/* File: verilog/psut_dip_filt.sv */
// Purpose: Output dip qualifier and stretcher
// Assumes: i_ms_tick is a one-cycle pulse every millisecond
// Notes: Warning rises once a dip has persisted the qualifying time
`timescale 1ns/1ns
module psut_dip_filt #(
	parameter int P_DIP_CYC = psut_pkg::DIP_MIN_CYC
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// Timing and condition
	input wire logic i_ms_tick,
	input wire logic i_dip,
	// Result
	output logic o_warn
);

	typedef struct packed {
		psut_pkg::psut_dip_e st;
		logic [16:0] qcnt;
		logic [8:0] hcnt;
		logic warn;
	} psut_dip_s;

	psut_dip_s q;
	psut_dip_s d;

	always_comb begin
		d = q;
		case (q.st)
			psut_pkg::PSUT_DIP_IDLE: begin
				if (i_dip) begin
					d.qcnt = 17'h00001;
					d.st = psut_pkg::PSUT_DIP_QUAL;
				end
			end
			psut_pkg::PSUT_DIP_QUAL: begin
				if (!i_dip) begin
					d.st = psut_pkg::PSUT_DIP_IDLE; // RULE17
				end else if (q.qcnt >= 17'(P_DIP_CYC - 1)) begin
					d.warn = 1'b1; // RULE15
					d.hcnt = 9'h000;
					d.st = psut_pkg::PSUT_DIP_HOLD;
				end else begin
					d.qcnt = q.qcnt + 17'h00001;
				end
			end
			psut_pkg::PSUT_DIP_HOLD: begin
				// One extra tick so a partial first millisecond still leaves the full length
				if (i_ms_tick && q.hcnt != 9'(psut_pkg::STRETCH_MS + 1)) begin
					d.hcnt = q.hcnt + 9'h001;
				end
				if (q.hcnt == 9'(psut_pkg::STRETCH_MS + 1) && !i_dip) begin
					d.warn = 1'b0; // RULE16
					d.st = psut_pkg::PSUT_DIP_IDLE;
				end
			end
			default: begin
				d.st = psut_pkg::PSUT_DIP_IDLE;
				d.warn = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			q <= '0;
			q.st <= psut_pkg::PSUT_DIP_IDLE;
		end else begin
			q <= d;
		end
	end

	assign o_warn = q.warn;

endmodule

/* File: verilog/psut_telemetry.sv */
// Purpose: Telemetry parameters, counters and events of the supply
// Assumes: Release of i_resetn marks a power-up; non-volatile values are valid then
// Notes: Published parameters change only at power-up and on the 50 ms refresh strobe
`timescale 1ns/1ns
module psut_telemetry #(
	parameter int P_MS_CYC = psut_pkg::MS_CYC,
	parameter int P_DIP_CYC = psut_pkg::DIP_MIN_CYC,
	parameter int P_MIN_MS = psut_pkg::MINUTE_MS,
	parameter int P_WIN_MS = psut_pkg::WIN_MS
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// Measurements
	input wire logic signed [9:0] i_temp_air,
	input wire logic signed [9:0] i_temp_pri,
	input wire logic [11:0] i_vin,
	input wire logic [12:0] i_vout,
	input wire logic [11:0] i_vset,
	input wire logic [15:0] i_iout,
	input wire logic i_reserve,
	input wire logic i_transient,
	// Non-volatile store
	input wire logic i_nv_ok,
	input wire logic [18:0] i_nv_op_hours,
	input wire logic [5:0] i_nv_op_minutes,
	input wire logic [22:0] i_nv_turn_ons,
	output logic o_nv_store,
	output logic [18:0] o_nv_op_hours,
	output logic [5:0] o_nv_op_minutes,
	output logic [22:0] o_nv_turn_ons,
	// Control
	input wire logic i_shutdown,
	output logic o_out_enable,
	// Published parameters
	output logic o_refresh,
	output logic signed [8:0] o_temp_air_max,
	output logic signed [8:0] o_temp_pri,
	output logic signed [8:0] o_temp_pri_max,
	output logic [18:0] o_op_hours,
	output logic [5:0] o_op_minutes,
	output logic [22:0] o_trans_total,
	output logic [22:0] o_trans_2min,
	output logic [10:0] o_vin,
	output logic [11:0] o_vout,
	output logic o_backfeed,
	output logic [22:0] o_turn_ons,
	output logic [19:0] o_up_hours,
	output logic [5:0] o_up_minutes,
	output logic o_nv_health,
	// Process data
	output logic [15:0] o_pd_current,
	output logic o_pd_strobe,
	// Events
	output logic o_output_good_event,
	output logic o_output_dip_warning,
	output logic o_overpower_event
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		psut_pkg::psut_main_e st;
		logic [16:0] div;
		logic ms;
		logic [5:0] rf_cnt;
		logic [1:0] pd_cnt;
		logic [16:0] min_cnt;
		logic [16:0] win_cnt;
		logic [8:0] rs_cnt;
		logic [18:0] op_h;
		logic [5:0] op_m;
		logic [19:0] up_h;
		logic [5:0] up_m;
		logic [22:0] ton;
		logic [22:0] tr_all;
		logic [22:0] tr_win;
		logic [22:0] tr_2m;
		logic refresh;
		psut_pkg::psut_temp_t air_max;
		psut_pkg::psut_temp_t pri;
		psut_pkg::psut_temp_t pri_max;
		logic [18:0] p_op_h;
		logic [5:0] p_op_m;
		logic [19:0] p_up_h;
		logic [5:0] p_up_m;
		logic [22:0] p_ton;
		logic [22:0] p_tr_all;
		logic [22:0] p_tr_2m;
		logic [10:0] vin;
		logic [11:0] vout;
		logic backfeed;
		logic nv_ok;
		logic nv_store;
		logic out_en;
		logic [15:0] pd;
		logic pd_stb;
		logic good;
		logic armed;
		logic good_ev;
		logic ovp;
	} psut_state_s;

	psut_state_s q;
	psut_state_s d;
	logic dip_warn;
	logic dip_now;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [22:0] sat_inc(input logic [22:0] v, input logic [22:0] mx);
		return (v >= mx) ? mx : v + 23'h000001;
	endfunction

	function automatic psut_pkg::psut_temp_t clamp_t(input logic signed [9:0] v);
		psut_pkg::psut_temp_t r;
		if (v < psut_pkg::TEMP_MIN) begin
			r = psut_pkg::TEMP_MIN;
		end else if (v > psut_pkg::TEMP_MAX) begin
			r = psut_pkg::TEMP_MAX;
		end else begin
			r = v[8:0];
		end
		return r;
	endfunction

	function automatic logic [22:0] scale(input logic [15:0] a, input logic [6:0] pct);
		return 23'(a) * 23'(pct);
	endfunction

	// Once the hours saturate, the minutes run on to their ceiling and both fields then stay there
	function automatic logic [25:0] tick_min(input logic [19:0] h, input logic [5:0] m,
		input logic [22:0] mx);
		logic [19:0] nh;
		logic [5:0] nm;
		nh = h;
		nm = m;
		if (m >= psut_pkg::MIN_MAX) begin
			if (23'(h) >= mx) begin
				nm = psut_pkg::MIN_MAX;
			end else begin
				nm = 6'h00;
				nh = 20'(sat_inc(23'(h), mx));
			end
		end else begin
			nm = m + 6'h01;
		end
		return {nh, nm};
	endfunction

	// ****************************************************************
	// Dip qualification
	// ****************************************************************
	// Only a supply that has reached its good level can dip
	assign dip_now = q.armed && q.out_en && !q.good; // RULE15

	psut_dip_filt #(
		.P_DIP_CYC(P_DIP_CYC)
	) u_dip (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_ms_tick(q.ms),
		.i_dip(dip_now),
		.o_warn(dip_warn)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [25:0] t;
		logic [11:0] vo;
		logic win_end;
		t = '0;
		vo = (i_vout > 13'(psut_pkg::VOUT_MAX)) ? psut_pkg::VOUT_MAX : i_vout[11:0]; // RULE8
		win_end = 1'b0;
		d = q;
		d.ms = 1'b0;
		d.refresh = 1'b0;
		d.pd_stb = 1'b0;
		d.nv_store = 1'b0;
		d.good_ev = 1'b0;

		// Millisecond enable
		if (q.div >= 17'(P_MS_CYC - 1)) begin
			d.div = 17'h00000;
			d.ms = 1'b1;
		end else begin
			d.div = q.div + 17'h00001;
		end

		case (q.st)
			psut_pkg::PSUT_INIT: begin
				// Power-up: restore stored totals and count this turn-on
				d.op_h = (23'(i_nv_op_hours) > psut_pkg::OPH_MAX) ? 19'(psut_pkg::OPH_MAX)
					: i_nv_op_hours; // RULE4
				d.op_m = (i_nv_op_minutes > psut_pkg::MIN_MAX) ? psut_pkg::MIN_MAX
					: i_nv_op_minutes; // RULE5
				d.ton = sat_inc(i_nv_turn_ons, psut_pkg::CNT_MAX); // RULE9
				d.nv_store = 1'b1;
				d.up_h = 20'h00000; // RULE10
				d.up_m = 6'h00; // RULE11
				d.air_max = psut_pkg::TEMP_MIN; // RULE1
				d.pri_max = psut_pkg::TEMP_MIN; // RULE3
				d.rf_cnt = 6'(psut_pkg::REFRESH_MS - 1);
				d.st = psut_pkg::PSUT_RUN;
			end
			psut_pkg::PSUT_RUN: begin
				// Elapsed time
				if (q.ms) begin
					if (q.min_cnt >= 17'(P_MIN_MS - 1)) begin
						d.min_cnt = 17'h00000;
						t = tick_min(20'(q.op_h), q.op_m, psut_pkg::OPH_MAX); // RULE22
						d.op_h = t[24:6]; // RULE4
						d.op_m = t[5:0]; // RULE5
						t = tick_min(q.up_h, q.up_m, psut_pkg::UPH_MAX); // RULE23
						d.up_h = t[25:6]; // RULE10
						d.up_m = t[5:0]; // RULE11
						d.nv_store = 1'b1;
					end else begin
						d.min_cnt = q.min_cnt + 17'h00001;
					end
					if (q.win_cnt >= 17'(P_WIN_MS - 1)) begin
						d.win_cnt = 17'h00000;
						win_end = 1'b1;
					end else begin
						d.win_cnt = q.win_cnt + 17'h00001;
					end
				end

				// Input transients; a pulse on the window edge lands in the closing window
				if (i_transient) begin
					d.tr_all = sat_inc(q.tr_all, psut_pkg::CNT_MAX); // RULE6
					d.tr_win = sat_inc(q.tr_win, psut_pkg::CNT_MAX); // RULE23
				end
				if (win_end) begin
					d.tr_2m = d.tr_win; // RULE6
					d.tr_win = 23'h000000;
				end

				// Process data
				if (q.ms) begin
					if (q.pd_cnt >= 2'(psut_pkg::PD_MS - 1)) begin
						d.pd_cnt = 2'h0;
						d.pd = i_iout; // RULE20
						d.pd_stb = 1'b1;
					end else begin
						d.pd_cnt = q.pd_cnt + 2'h1;
					end
				end

				// Parameter refresh
				if (q.ms) begin
					if (q.rf_cnt >= 6'(psut_pkg::REFRESH_MS - 1)) begin
						d.rf_cnt = 6'h00;
						d.refresh = 1'b1; // RULE19
					end else begin
						d.rf_cnt = q.rf_cnt + 6'h01;
					end
				end

				// Shut-down acts at once, restart waits out the turn-on delay
				if (i_shutdown) begin
					d.out_en = 1'b0; // RULE13
					d.rs_cnt = 9'h000;
				end else if (!q.out_en && q.ms) begin
					if (q.rs_cnt >= 9'(psut_pkg::RESTART_MS - 1)) begin
						d.out_en = 1'b1; // RULE21
					end else begin
						d.rs_cnt = q.rs_cnt + 9'h001;
					end
				end
			end
			default: begin
				d.st = psut_pkg::PSUT_INIT;
			end
		endcase

		// Snapshot for the master; the refresh strobe is one cycle ahead of the values
		if (q.refresh || q.st == psut_pkg::PSUT_INIT) begin
			d.air_max = ($signed(clamp_t(i_temp_air)) > $signed(q.air_max)) ? clamp_t(i_temp_air)
				: q.air_max; // RULE1
			d.pri = clamp_t(i_temp_pri); // RULE2
			d.pri_max = ($signed(clamp_t(i_temp_pri)) > $signed(q.pri_max)) ? clamp_t(i_temp_pri)
				: q.pri_max; // RULE3
			if (q.st == psut_pkg::PSUT_INIT) begin
				d.air_max = clamp_t(i_temp_air);
				d.pri_max = clamp_t(i_temp_pri);
			end
			d.vin = (i_vin > 12'(psut_pkg::VIN_MAX)) ? psut_pkg::VIN_MAX : i_vin[10:0]; // RULE7
			d.vout = vo; // RULE8
			d.backfeed = (vo > i_vset); // RULE8
			d.nv_ok = i_nv_ok; // RULE12
			d.p_op_h = d.op_h; // RULE19
			d.p_op_m = d.op_m;
			d.p_up_h = d.up_h;
			d.p_up_m = d.up_m;
			d.p_ton = d.ton;
			d.p_tr_all = d.tr_all;
			d.p_tr_2m = d.tr_2m;
		end

		// Events follow the live readings, not the snapshot
		d.good = (scale(16'(vo), psut_pkg::PCT_FULL) >= scale(16'(i_vset), psut_pkg::GOOD_PCT));
		d.good_ev = d.good && !q.good && q.out_en; // RULE14
		if (!q.out_en) begin
			d.armed = 1'b0;
		end else if (q.good) begin
			d.armed = 1'b1;
		end
		d.ovp = i_reserve
			&& (scale(i_iout, psut_pkg::PCT_FULL) > scale(psut_pkg::INOM, psut_pkg::OVP_PCT)); // RULE18
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			q <= '0;
			q.st <= psut_pkg::PSUT_INIT;
			q.air_max <= psut_pkg::TEMP_MIN;
			q.pri <= psut_pkg::TEMP_MIN;
			q.pri_max <= psut_pkg::TEMP_MIN;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_nv_store = q.nv_store;
	assign o_nv_op_hours = q.op_h;
	assign o_nv_op_minutes = q.op_m;
	assign o_nv_turn_ons = q.ton;
	assign o_out_enable = q.out_en;
	assign o_refresh = q.refresh;
	assign o_temp_air_max = q.air_max;
	assign o_temp_pri = q.pri;
	assign o_temp_pri_max = q.pri_max;
	assign o_op_hours = q.p_op_h;
	assign o_op_minutes = q.p_op_m;
	assign o_trans_total = q.p_tr_all;
	assign o_trans_2min = q.p_tr_2m;
	assign o_vin = q.vin;
	assign o_vout = q.vout;
	assign o_backfeed = q.backfeed;
	assign o_turn_ons = q.p_ton;
	assign o_up_hours = q.p_up_h;
	assign o_up_minutes = q.p_up_m;
	assign o_nv_health = q.nv_ok;
	assign o_pd_current = q.pd;
	assign o_pd_strobe = q.pd_stb;
	assign o_output_good_event = q.good_ev;
	assign o_output_dip_warning = dip_warn;
	assign o_overpower_event = q.ovp;

endmodule

/* File: testbench/psut_telemetry_chk.sv */
// Purpose: Port assertions for the telemetry block
// Assumes: Bench shortens the millisecond to P_MS_CYC cycles
// Notes: Counters stand in for delays too long to unroll
`timescale 1ns/1ns
module psut_telemetry_chk #(
	parameter int P_MS_CYC = psut_pkg::MS_CYC
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// Inputs watched
	input wire logic i_shutdown,
	input wire logic i_reserve,
	input wire logic [15:0] i_iout,
	// Outputs watched
	input wire logic o_out_enable,
	input wire logic o_refresh,
	input wire logic o_pd_strobe,
	input wire logic signed [8:0] o_temp_air_max,
	input wire logic signed [8:0] o_temp_pri,
	input wire logic signed [8:0] o_temp_pri_max,
	input wire logic [5:0] o_op_minutes,
	input wire logic [5:0] o_up_minutes,
	input wire logic [10:0] o_vin,
	input wire logic [11:0] o_vout,
	input wire logic o_output_good_event,
	input wire logic o_output_dip_warning,
	input wire logic o_overpower_event
);
	// *****
	// Helper counters
	// *****
	logic [15:0] ref_q, pd_q, warn_q, off_q;
	logic [2:0] up_q;
	logic ref_seen_q, pd_seen_q;
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			ref_q <= 16'h0000;
			pd_q <= 16'h0000;
			warn_q <= 16'h0000;
			off_q <= 16'h0000;
			up_q <= 3'h0;
			ref_seen_q <= 1'b0;
			pd_seen_q <= 1'b0;
		end else begin
			ref_q <= o_refresh ? 16'h0000 : ref_q + 16'h0001;
			pd_q <= o_pd_strobe ? 16'h0000 : pd_q + 16'h0001;
			warn_q <= o_output_dip_warning ? warn_q + 16'h0001 : 16'h0000;
			off_q <= i_shutdown ? 16'h0000 : ((off_q == 16'hFFFF) ? off_q : off_q + 16'h0001);
			up_q <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
			ref_seen_q <= ref_seen_q | o_refresh;
			pd_seen_q <= pd_seen_q | o_pd_strobe;
		end
	end
	// *****
	// Assertions
	// *****
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	a_shut_off_fast:
		assert property (i_shutdown |=> !o_out_enable) else $error("output stays on under shut-down");
	a_restart_delay:
		assert property ($rose(o_out_enable) |-> off_q >= 348 * P_MS_CYC && off_q <= 351 * P_MS_CYC)
		else $error("output restart delay wrong");
	a_temp_range:
		assert property (o_temp_pri >= psut_pkg::TEMP_MIN && o_temp_pri <= psut_pkg::TEMP_MAX)
		else $error("primary temperature out of span");
	a_peak_order:
		assert property (o_temp_pri_max >= o_temp_pri && o_temp_air_max <= psut_pkg::TEMP_MAX
			&& o_temp_air_max >= psut_pkg::TEMP_MIN) else $error("peak tracker wrong");
	a_minute_cap:
		assert property (o_op_minutes <= psut_pkg::MIN_MAX && o_up_minutes <= psut_pkg::MIN_MAX)
		else $error("minutes above limit");
	a_volt_cap:
		assert property (o_vin <= psut_pkg::VIN_MAX && o_vout <= psut_pkg::VOUT_MAX) else $error("voltage above cap");
	a_pub_hold:
		assert property (up_q == 3'h7 && !$past(o_refresh) |-> $stable(o_vin) && $stable(o_temp_pri)
			&& $stable(o_op_minutes)) else $error("published value moved between refreshes");
	a_refresh_gap:
		assert property (o_refresh && ref_seen_q |-> ref_q == 50 * P_MS_CYC - 1) else $error("refresh period wrong");
	a_pd_gap:
		assert property (o_pd_strobe && pd_seen_q |-> pd_q == 2 * P_MS_CYC - 1) else $error("process data period wrong");
	a_good_pulse:
		assert property (o_output_good_event |=> !o_output_good_event) else $error("good event longer than a cycle");
	a_dip_stretch:
		assert property ($fell(o_output_dip_warning) |-> warn_q >= 250 * P_MS_CYC) else $error("dip warning too short");
	a_over_power:
		assert property (up_q > 3'h1 |-> o_overpower_event == $past(i_reserve && i_iout > 16'h01A4))
		else $error("overpower event wrong");
	c_refresh: cover property (o_refresh);
	c_good: cover property (o_output_good_event);
	c_dip: cover property ($rose(o_output_dip_warning));
	c_over: cover property (o_overpower_event);
endmodule

bind psut_telemetry psut_telemetry_chk #(.P_MS_CYC(P_MS_CYC)) u_psut_telemetry_chk (.*);

/* File: testbench/psut_master_model.sv */
// Purpose: Link master that writes the shut-down bit and reads process data
// Assumes: Bench commands the bit; words are taken while the strobe stands
// Notes: Behavioural only
`timescale 1ns/1ns
module psut_master_model (
	// Clock
	input wire logic i_clk_sys,
	// Command and device answers
	input wire logic i_cmd_off,
	input wire logic [15:0] i_pd_current,
	input wire logic i_pd_strobe,
	// To the device and the bench
	output logic o_shutdown,
	output logic [15:0] o_pd_word,
	output int o_pd_count
);
	initial begin
		o_shutdown = 1'b0;
		o_pd_word = 16'h0000;
		o_pd_count = 0;
	end
	// Non-blocking write on the sampling edge, so the bench's falling-edge command never races it
	always @(posedge i_clk_sys) o_shutdown <= i_cmd_off;
	always @(posedge i_clk_sys) begin
		if (i_pd_strobe === 1'b1) begin
			o_pd_word <= i_pd_current;
			o_pd_count <= o_pd_count + 1;
		end
	end
endmodule

/* File: testbench/psut_telemetry_tb_top.sv */
// Purpose: Self-checking bench for the telemetry block
// Assumes: Millisecond shortened to 10 cycles, minute to 5 ms
// Notes: Inputs change at the falling edge
`timescale 1ns/1ns
module psut_telemetry_tb_top;
	localparam int MS = 10;
	logic i_clk_sys, i_resetn, i_reserve, i_transient, i_nv_ok, i_shutdown, cmd_off, gd, wn;
	logic signed [9:0] i_temp_air, i_temp_pri;
	logic [11:0] i_vin, i_vset;
	logic [12:0] i_vout;
	logic [15:0] i_iout, pd_word, o_pd_current;
	logic [18:0] i_nv_op_hours, o_nv_op_hours, o_op_hours;
	logic [5:0] i_nv_op_minutes, o_nv_op_minutes, o_op_minutes, o_up_minutes;
	logic [22:0] i_nv_turn_ons, o_nv_turn_ons, o_trans_total, o_trans_2min, o_turn_ons;
	logic o_nv_store, o_out_enable, o_refresh, o_backfeed, o_nv_health, o_pd_strobe;
	logic o_output_good_event, o_output_dip_warning, o_overpower_event;
	logic signed [8:0] o_temp_air_max, o_temp_pri, o_temp_pri_max;
	logic [10:0] o_vin;
	logic [11:0] o_vout;
	logic [19:0] o_up_hours;
	int failures, checks_done, pd_count, cyc, t_rel, air_pk, pri_pk, trans, base_m, wc;
	// Transients per 2-minute window, indexed by the edge that samples them
	int win_tr[200];

	psut_telemetry #(.P_MS_CYC(MS), .P_DIP_CYC(20), .P_MIN_MS(5), .P_WIN_MS(10)) u_psut_telemetry (.*);
	psut_master_model u_psut_master_model (.i_clk_sys(i_clk_sys), .i_cmd_off(cmd_off),
		.i_pd_current(o_pd_current), .i_pd_strobe(o_pd_strobe), .o_shutdown(i_shutdown),
		.o_pd_word(pd_word), .o_pd_count(pd_count));

	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) cyc <= cyc + 1;

	// *****
	// Checking and model helpers
	// *****
	function automatic int clp(int v, int lo, int hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
	function automatic int mx(int a, int b);
		return (a > b) ? a : b;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic power_up(input logic [22:0] tons, input logic [18:0] hrs, input logic [5:0] mins);
		i_resetn = 1'b0;
		i_nv_turn_ons = tons;
		i_nv_op_hours = hrs;
		i_nv_op_minutes = mins;
		base_m = hrs * 60 + mins;
		air_pk = clp(i_temp_air, -45, 150);
		pri_pk = clp(i_temp_pri, -45, 150);
		trans = 0;
		repeat (10) @(negedge i_clk_sys);
		i_resetn = 1'b1;
		t_rel = cyc;
		// Init runs on the first edge after release
		@(negedge i_clk_sys);
		chk(o_nv_store, 1'b1);
		chk(o_nv_turn_ons, (tons == psut_pkg::CNT_MAX) ? tons : tons + 23'h000001);
		chk(o_turn_ons, (tons == psut_pkg::CNT_MAX) ? tons : tons + 23'h000001);
	endtask
	task automatic wait_on();
		int n;
		n = 0;
		while (o_out_enable !== 1'b1 && n < 4000) begin
			@(negedge i_clk_sys);
			n++;
		end
		chk(n >= 348 * MS && n <= 351 * MS, 1'b1);
	endtask
	task automatic round(input logic full);
		int ta, tp, et, pc, up, k;
		ta = $urandom_range(260) - 80;
		tp = $urandom_range(260) - 80;
		i_temp_air = 10'(ta);
		i_temp_pri = 10'(tp);
		i_vin = 12'($urandom_range(1300));
		i_vout = 13'($urandom_range(4200));
		i_nv_ok = 1'($urandom_range(1));
		i_iout = 16'(400 + $urandom_range(40));
		air_pk = mx(air_pk, clp(ta, -45, 150));
		pri_pk = mx(pri_pk, clp(tp, -45, 150));
		pc = pd_count;
		k = 0;
		do begin
			@(negedge i_clk_sys);
			k++;
			i_reserve = 1'($urandom_range(1));
			// No pulse on the snapshot edge, whose count is ambiguous
			i_transient = (o_refresh !== 1'b1) && ($urandom_range(7) == 0);
			trans += i_transient;
			win_tr[(cyc - t_rel - 1) / 100] += i_transient;
		end while (o_refresh !== 1'b1 && k < 600);
		et = trans;
		@(negedge i_clk_sys);
		i_transient = 1'b0;
		up = o_up_hours * 60 + o_up_minutes;
		chk(o_temp_air_max, air_pk);
		chk(o_temp_pri, clp(tp, -45, 150));
		chk(o_temp_pri_max, pri_pk);
		chk(o_trans_total, et);
		chk(o_trans_2min, win_tr[(cyc - t_rel - 101) / 100]);
		chk(o_vin, clp(i_vin, 0, 1130));
		chk(o_vout, clp(i_vout, 0, 4000));
		chk(o_backfeed, clp(i_vout, 0, 4000) > i_vset);
		chk(o_nv_health, i_nv_ok);
		chk(o_op_hours * 60 + o_op_minutes - base_m, up);
		chk((cyc - t_rel) / (5 * MS) - up <= 2, 1'b1);
		if (full) begin
			chk(pd_count - pc, 25);
			chk(pd_word, i_iout);
		end
	endtask
	task automatic dip(input int len);
		gd = 1'b0;
		wn = 1'b0;
		wc = 0;
		i_vout = 13'h086F;
		for (int i = 0; i < len + 60; i++) begin
			@(negedge i_clk_sys);
			// Reading stays low for len sampling edges
			i_vout = (i + 1 >= len) ? 13'h0870 : i_vout;
			wc += o_output_dip_warning;
			wn |= o_output_dip_warning;
			gd |= o_output_good_event;
		end
		while (o_output_dip_warning === 1'b1 && wc < 4000) begin
			@(negedge i_clk_sys);
			wc++;
		end
	endtask

	// *****
	// Main sequence
	// *****
	initial begin
		void'($urandom(69));
		cmd_off = 1'b0;
		i_vset = 12'h960;
		i_transient = 1'b0;
		i_reserve = 1'b0;
		i_iout = 16'h0190;
		i_vout = 13'h0870;
		i_vin = 12'h190;
		i_nv_ok = 1'b1;
		i_temp_air = 10'sh019;
		i_temp_pri = 10'sh01E;
		power_up(23'h000010, 19'h00064, 6'h3A);
		wait_on();
		for (int r = 0; r < 8; r++) round(r > 0);
		i_vout = 13'h0870;
		repeat (2600) @(negedge i_clk_sys);
		dip(5);
		chk(gd, 1'b1);
		chk(wn, 1'b0);
		dip(40);
		chk(wn, 1'b1);
		chk(wc >= 250 * MS && wc <= 2525, 1'b1);
		cmd_off = 1'b1;
		repeat (4) @(negedge i_clk_sys);
		chk(o_out_enable, 1'b0);
		cmd_off = 1'b0;
		wait_on();
		power_up(psut_pkg::CNT_MAX, 19'(psut_pkg::OPH_MAX), 6'h3A);
		repeat (200) @(negedge i_clk_sys);
		chk(o_nv_op_hours, 19'(psut_pkg::OPH_MAX));
		chk(o_nv_op_minutes, psut_pkg::MIN_MAX);
		stop_test();
	end

	// Whole run is near 16000 cycles; allow more than twice that
	initial begin
		#400000;
		failures++;
		stop_test();
	end
endmodule
